// >>> bench/esp_peer.sv
// Remote serial peer: async frames and mode 0 shift partner
`timescale 1ns/1ps
module esp_peer (
	input wire ref_clk,
	input wire txd_out,
	input wire rxd_out,
	input wire rxd_oe,
	output wire rxd_in
);
	reg drv = 1'b1;
	// Pulled up when nobody drives
	assign rxd_in = rxd_oe ? rxd_out : drv;
	task send(input [10:0] v, input integer n, input integer per);
		integer i;
		begin
			for (i = 0; i < n; i = i + 1) begin
				drv <= v[i];
				repeat (per) @(posedge ref_clk);
			end
			drv <= 1'b1;
			// Idle long enough for the receiver to see a fresh start edge
			repeat (4) @(posedge ref_clk);
		end
	endtask
	// Samples mid bit; the last sample is stop then idle
	task recv(output [10:0] v, input integer per);
		integer i;
		begin
			v = 11'h000;
			@(negedge txd_out);
			repeat (per / 2) @(posedge ref_clk);
			for (i = 0; i < 11; i = i + 1) begin
				v[i] = txd_out;
				repeat (per) @(posedge ref_clk);
			end
		end
	endtask
	task m0_take(output [7:0] v);
		integer i;
		for (i = 0; i < 8; i = i + 1) begin
			@(posedge txd_out);
			v[i] = rxd_out;
		end
	endtask
	task m0_feed(input [7:0] v);
		integer i;
		begin
			for (i = 0; i < 8; i = i + 1) begin
				@(negedge txd_out);
				drv <= v[i];
			end
			repeat (8) @(posedge ref_clk);
			drv <= 1'b1;
		end
	endtask
endmodule // esp_peer

// >>> bench/esp_top_properties.sv
// Concurrent checks on the serial port pins and register bus
`timescale 1ns/1ps
module esp_props (
	input wire ref_clk,
	input wire rst,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire rxd_out,
	input wire rxd_oe,
	input wire txd_out
);
	reg view_q;
	reg [1:0] mode_q;
	// Bit 7 writes the error flag, not the mode, while the view bit is up
	always @(posedge ref_clk) begin
		if (rst) begin
			view_q <= 1'b0;
			mode_q <= 2'h0;
		end else if (reg_wr && reg_addr == 8'h87) begin
			view_q <= reg_wdata[6];
		end else if (reg_wr && reg_addr == 8'h98) begin
			mode_q <= {view_q ? mode_q[1] : reg_wdata[7], reg_wdata[6]};
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not idle");
	chk_unmapped_zero: assert property (reg_rd && reg_addr != 8'h98 && reg_addr != 8'h99
		&& reg_addr != 8'h87 |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
	chk_tx_start: assert property (reg_wr && reg_addr == 8'h99 |-> ##[1:3] !txd_out)
		else $error("no transmit start");
	chk_oe_mode0: assert property (rxd_oe |-> mode_q == 2'h0)
		else $error("data pin driven outside mode 0");
	chk_m0_clock: assert property (rxd_oe && $fell(txd_out)
		|-> !txd_out[*3] ##1 txd_out[*3]) else $error("shift clock shape");
	chk_m0_hold: assert property (rxd_oe && $fell(txd_out) |=> $stable(rxd_out)[*5])
		else $error("shift data moved");
	chk_pwr_readback: assert property (reg_wr && reg_addr == 8'h87 ##1 reg_rd
		&& reg_addr == 8'h87 |=> reg_rdata[7:6] == $past(reg_wdata[7:6], 2))
		else $error("power control readback");
	chk_m2_bit_len: assert property (mode_q == 2'h2 && $fell(txd_out) |-> !txd_out[*8])
		else $error("mode 2 bit too short");
	cover property (rxd_oe && $fell(txd_out));
	cover property (mode_q == 2'h3 && $fell(txd_out));
	cover property (reg_rd && reg_addr == 8'h99);
endmodule // esp_props
bind esp_top esp_props u_props (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out));

// >>> bench/esp_top_tb.sv
// Self-checking bench for the serial port
`timescale 1ns/1ps
module esp_top_tb;
	reg ref_clk = 1'b0;
	reg rst = 1'b1;
	reg [7:0] reg_addr = 8'h00;
	reg [7:0] reg_wdata = 8'h00;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	reg t1_ovf_tick = 1'b0;
	wire [7:0] reg_rdata;
	wire rxd_in;
	wire rxd_out;
	wire rxd_oe;
	wire txd_out;
	integer n_errors = 0;
	integer check_count = 0;
	reg [10:0] f;
	reg [7:0] d;
	always #20 ref_clk = ~ref_clk;
	// Overflow every other clock, so one bit is 32 clocks in modes 1 and 3
	always @(posedge ref_clk) t1_ovf_tick <= ~t1_ovf_tick;
	esp_top u_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .t1_ovf_tick(t1_ovf_tick),
		.rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out));
	esp_peer u_peer (.ref_clk(ref_clk), .txd_out(txd_out), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
		.rxd_in(rxd_in));
	task chk(input [10:0] g, input [10:0] e);
		begin
			check_count = check_count + 1;
			if (g !== e) begin
				n_errors = n_errors + 1;
				$display("BAD %0t got %h want %h", $time, g, e);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] v);
		begin
			reg_addr <= a;
			reg_wdata <= v;
			reg_wr <= 1'b1;
			@(posedge ref_clk);
			reg_wr <= 1'b0;
		end
	endtask
	task rchk(input [7:0] a, input [7:0] m, input [7:0] e);
		begin
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge ref_clk);
			reg_rd <= 1'b0;
			@(negedge ref_clk);
			chk(reg_rdata & m, e);
			@(posedge ref_clk);
		end
	endtask
	task txf(input [7:0] c, input integer per, input [7:0] v, input [10:0] e);
		begin
			wr(8'h98, c);
			@(posedge ref_clk);
			fork
				u_peer.recv(f, per);
				wr(8'h99, v);
			join
			chk(f, e);
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d errors %0d", check_count, n_errors);
			if (n_errors == 0 && check_count > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		rchk(8'h98, 8'hFF, 8'h00);
		rchk(8'h55, 8'hFF, 8'h00);
		wr(8'h87, 8'h80);
		rchk(8'h87, 8'hC0, 8'h80);
		txf(8'h98, 16, 8'hA5, {2'b11, 8'hA5, 1'b0});
		rchk(8'h98, 8'h02, 8'h02);
		wr(8'h98, 8'h90);
		u_peer.send({2'b10, 8'h3C, 1'b0}, 11, 16);
		rchk(8'h98, 8'hFF, 8'h91);
		rchk(8'h99, 8'hFF, 8'h3C);
		$display("mode 2 done");
		wr(8'h98, 8'hB0);
		u_peer.send({2'b10, 8'h77, 1'b0}, 11, 16);
		rchk(8'h98, 8'hFF, 8'hB0);
		u_peer.send({2'b11, 8'h5A, 1'b0}, 11, 16);
		u_peer.send({2'b11, 8'hC3, 1'b0}, 11, 16);
		rchk(8'h99, 8'hFF, 8'hC3);
		rchk(8'h98, 8'hFF, 8'hB5);
		$display("filter done");
		wr(8'h87, 8'hC0);
		u_peer.send({2'b01, 8'h55, 1'b0}, 11, 16);
		rchk(8'h98, 8'h80, 8'h80);
		u_peer.send({2'b11, 8'h11, 1'b0}, 11, 16);
		rchk(8'h98, 8'h80, 8'h80);
		wr(8'h98, 8'h10);
		rchk(8'h98, 8'h80, 8'h00);
		wr(8'h87, 8'h80);
		rchk(8'h98, 8'h80, 8'h80);
		$display("framing done");
		wr(8'h98, 8'h50);
		@(posedge ref_clk);
		fork
			u_peer.send({2'b11, 8'h81, 1'b0}, 10, 32);
			u_peer.recv(f, 32);
			wr(8'h99, 8'h6E);
		join
		chk(f, {2'b11, 8'h6E, 1'b0});
		rchk(8'h99, 8'hFF, 8'h81);
		rchk(8'h98, 8'h07, 8'h07);
		txf(8'hC8, 32, 8'h12, {2'b11, 8'h12, 1'b0});
		$display("modes 1 and 3 done");
		wr(8'h98, 8'h00);
		@(posedge ref_clk);
		fork
			u_peer.m0_take(d);
			wr(8'h99, 8'h96);
		join
		chk(d, 8'h96);
		fork
			u_peer.m0_feed(8'h4B);
			wr(8'h98, 8'h10);
		join
		rchk(8'h99, 8'hFF, 8'h4B);
		rchk(8'h98, 8'h01, 8'h01);
		$display("mode 0 done");
		finish_test;
	end
	// Whole sequence needs under 6000 clocks
	initial begin
		repeat (30000) @(posedge ref_clk);
		n_errors = n_errors + 1;
		finish_test;
	end
endmodule // esp_top_tb

// >>> verilog/esp_regs.vh
// Register map, field positions and timing counts of the serial port
`ifndef ESP_REGS_VH
`define ESP_REGS_VH
`define ESP_ADDR_CTRL 8'h98
`define ESP_ADDR_BUF 8'h99
`define ESP_ADDR_PWR 8'h87
`define ESP_CTRL_RESET 8'h00
`define ESP_PWR_RESET 8'h00
`define ESP_BIT_SM0 7
`define ESP_BIT_SM1 6
`define ESP_BIT_SM2 5
`define ESP_BIT_REN 4
`define ESP_BIT_TB8 3
`define ESP_BIT_RB8 2
`define ESP_BIT_TI 1
`define ESP_BIT_RI 0
`define ESP_BIT_RATE 7
`define ESP_BIT_VIEW 6
`define ESP_MODE0 2'h0
`define ESP_MODE1 2'h1
`define ESP_MODE2 2'h2
`define ESP_MODE3 2'h3
`define ESP_M0_DIV 4'h6
`define ESP_M0_HALF 4'h3
`define ESP_OVS_LAST 4'hF
`define ESP_OVS_MID 4'h7
`endif

// >>> verilog/esp_top.v
// Full-duplex serial port with shift-register and 8/9-bit async modes
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`include "esp_regs.vh"

// Functional notes
// - Timer tick rate in modes 1,3; fixed else
// - Async transmit and receive run independently
// - One byte buffered; unread byte overwritten
// - Buffer write loads tx; read returns rx
// - Mode 0: 8 bits, clock out, CPU/6
// - Mode 1: start, 8 data LSB first, stop
// - Mode 1: stop bit lands in rx_ninth_bit
// - Modes 2,3: start, 8 data, ninth, stop
// - Modes 2,3: send tx_ninth_bit as ninth
// - Modes 2,3: store ninth, stop only flags error
// - Mode 2 rate CPU/16 or CPU/32
// - Mode 3 is mode 2 with timer rate
// - Buffer write starts transmission
// - Mode 0 receives when done clear, enabled
// - Async receive starts on start bit if enabled
// - Missing stop bit recorded as framing error
// - Bit 7 shows mode or framing error
// - Framing error sticky until software clears
// - Control register at 98h, reset 00h
// - Multiprocessor filter suppresses receive-done
// - Invalid stop sets framing error flag
module esp_top (
	input wire ref_clk,
	input wire rst,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire t1_ovf_tick,
	input wire rxd_in,
	output reg rxd_out,
	output reg rxd_oe,
	output reg txd_out
);

// Async receiver states
localparam RX_IDLE = 2'h0;
localparam RX_START = 2'h1;
localparam RX_DATA = 2'h2;
localparam RX_STOP = 2'h3;

// Control and power-control fields
reg sm0_q;
reg sm1_q;
reg sm2_q;
reg ren_q;
reg tb8_q;
reg rb8_q;
reg ti_q;
reg ri_q;
reg fe_q;
reg rate_sel_q;
reg view_sel_q;
reg [7:0] rbuf_q;

// Input synchroniser and filtered level
reg rxd_s1_q;
reg rxd_s2_q;
reg rxd_s3_q;
reg rxd_v_q;
reg rxd_prev_q;

// Rate generation
reg div2_q;

// Mode 0 shifter
reg m0_busy_q;
reg m0_rx_q;
reg [3:0] m0_ph_q;
reg [3:0] m0_cnt_q;
reg [7:0] m0_sh_q;

// Async transmitter
reg tx_busy_q;
reg [10:0] tx_sh_q;
reg [3:0] tx_bits_q;
reg [3:0] tx_tick_q;

// Async receiver
reg [1:0] rx_st_q;
reg [3:0] rx_tick_q;
reg [3:0] rx_bits_q;
reg [8:0] rx_sh_q;

wire [1:0] mode;
wire is_m0;
wire nine;
wire wr_ctrl;
wire wr_buf;
wire wr_pwr;
wire s16;
wire fall;
reg m0_done;
reg tx_done;
reg rx_load;
reg rx_ninth;
reg fe_set;
reg [7:0] rx_byte;

assign mode = {sm0_q, sm1_q};
assign is_m0 = (mode == `ESP_MODE0);
assign nine = mode[1];
assign wr_ctrl = reg_wr && (reg_addr == `ESP_ADDR_CTRL);
assign wr_buf = reg_wr && (reg_addr == `ESP_ADDR_BUF);
assign wr_pwr = reg_wr && (reg_addr == `ESP_ADDR_PWR);
// Oversample tick: mode 2 from the CPU clock, modes 1 and 3 from timer 1
assign s16 = (mode == `ESP_MODE2) ? (rate_sel_q | div2_q) : t1_ovf_tick;
assign fall = rxd_prev_q && !rxd_v_q;

always @(posedge ref_clk) begin
	if (rst) begin
		div2_q <= 1'b0;
	end else begin
		div2_q <= ~div2_q;
	end
end

// Pin level counts once the second and third stages agree
always @(posedge ref_clk) begin
	if (rst) begin
		rxd_s1_q <= 1'b1;
		rxd_s2_q <= 1'b1;
		rxd_s3_q <= 1'b1;
		rxd_v_q <= 1'b1;
		rxd_prev_q <= 1'b1;
	end else begin
		rxd_s1_q <= rxd_in;
		rxd_s2_q <= rxd_s1_q;
		rxd_s3_q <= rxd_s2_q;
		if (rxd_s2_q == rxd_s3_q) begin
			rxd_v_q <= rxd_s3_q;
		end
		rxd_prev_q <= rxd_v_q;
	end
end

// Mode 0: one bit per six clocks, shift clock low then high
// Completion strobes decoded from state, so every clocked process sees them alike
always @* begin
	m0_done = is_m0 && !wr_buf && m0_busy_q && (m0_ph_q == `ESP_M0_DIV - 4'h1) &&
		(m0_cnt_q == 4'h1);
	tx_done = !is_m0 && !wr_buf && tx_busy_q && s16 && (tx_tick_q == `ESP_OVS_LAST) &&
		(tx_bits_q == 4'h1);
	fe_set = 1'b0;
	rx_load = 1'b0;
	rx_ninth = 1'b0;
	rx_byte = 8'h00;
	if (!is_m0 && (rx_st_q == RX_STOP) && s16 && (rx_tick_q == `ESP_OVS_LAST)) begin
		fe_set = !rxd_v_q;
		if (nine) begin
			rx_byte = rx_sh_q[7:0];
			rx_ninth = rx_sh_q[8];
			rx_load = !sm2_q || rx_sh_q[8];
		end else begin
			rx_byte = rx_sh_q[8:1];
			rx_ninth = rxd_v_q;
			rx_load = !sm2_q || rxd_v_q;
		end
	end
end

always @(posedge ref_clk) begin
	if (rst) begin
		m0_busy_q <= 1'b0;
		m0_rx_q <= 1'b0;
		m0_ph_q <= 4'h0;
		m0_cnt_q <= 4'h0;
		m0_sh_q <= 8'h00;
	end else if (is_m0 && wr_buf) begin
		m0_busy_q <= 1'b1;
		m0_rx_q <= 1'b0;
		m0_ph_q <= 4'h0;
		m0_cnt_q <= 4'h8;
		m0_sh_q <= reg_wdata;
	end else if (!is_m0) begin
		m0_busy_q <= 1'b0;
	end else if (!m0_busy_q) begin
		if (!ri_q && ren_q) begin
			m0_busy_q <= 1'b1;
			m0_rx_q <= 1'b1;
			m0_ph_q <= 4'h0;
			m0_cnt_q <= 4'h8;
		end
	end else if (m0_ph_q == `ESP_M0_DIV - 4'h1) begin
		m0_ph_q <= 4'h0;
		// Late sample leaves room for the synchroniser delay
		m0_sh_q <= {m0_rx_q ? rxd_v_q : 1'b1, m0_sh_q[7:1]};
		m0_cnt_q <= m0_cnt_q - 4'h1;
		if (m0_cnt_q == 4'h1) begin
			m0_busy_q <= 1'b0;
		end
	end else begin
		m0_ph_q <= m0_ph_q + 4'h1;
	end
end

// Async transmitter, 16 ticks per bit
always @(posedge ref_clk) begin
	if (rst) begin
		tx_busy_q <= 1'b0;
		tx_sh_q <= 11'h7FF;
		tx_bits_q <= 4'h0;
		tx_tick_q <= 4'h0;
	end else if (!is_m0 && wr_buf) begin
		tx_busy_q <= 1'b1;
		tx_tick_q <= 4'h0;
		if (nine) begin
			tx_sh_q <= {1'b1, tb8_q, reg_wdata, 1'b0};
			tx_bits_q <= 4'hB;
		end else begin
			tx_sh_q <= {2'h3, reg_wdata, 1'b0};
			tx_bits_q <= 4'hA;
		end
	end else if (is_m0) begin
		tx_busy_q <= 1'b0;
	end else if (tx_busy_q && s16) begin
		tx_tick_q <= tx_tick_q + 4'h1;
		if (tx_tick_q == `ESP_OVS_LAST) begin
			tx_sh_q <= {1'b1, tx_sh_q[10:1]};
			tx_bits_q <= tx_bits_q - 4'h1;
			if (tx_bits_q == 4'h1) begin
				tx_busy_q <= 1'b0;
			end
		end
	end
end

// Async receiver, sampling mid-bit at 16x
always @(posedge ref_clk) begin
	if (rst) begin
		rx_st_q <= RX_IDLE;
		rx_tick_q <= 4'h0;
		rx_bits_q <= 4'h0;
		rx_sh_q <= 9'h000;
	end else if (is_m0) begin
		rx_st_q <= RX_IDLE;
	end else begin
		case (rx_st_q)
		RX_IDLE: begin
			if (fall && ren_q) begin
				rx_st_q <= RX_START;
				rx_tick_q <= 4'h0;
			end
		end
		RX_START: begin
			if (s16) begin
				rx_tick_q <= rx_tick_q + 4'h1;
				if (rx_tick_q == `ESP_OVS_MID) begin
					// A glitch shorter than half a bit is dropped
					rx_st_q <= rxd_v_q ? RX_IDLE : RX_DATA;
					rx_tick_q <= 4'h0;
					rx_bits_q <= nine ? 4'h9 : 4'h8;
				end
			end
		end
		RX_DATA: begin
			if (s16) begin
				rx_tick_q <= rx_tick_q + 4'h1;
				if (rx_tick_q == `ESP_OVS_LAST) begin
					rx_sh_q <= {rxd_v_q, rx_sh_q[8:1]};
					rx_bits_q <= rx_bits_q - 4'h1;
					if (rx_bits_q == 4'h1) begin
						rx_st_q <= RX_STOP;
					end
				end
			end
		end
		RX_STOP: begin
			if (s16) begin
				rx_tick_q <= rx_tick_q + 4'h1;
				if (rx_tick_q == `ESP_OVS_LAST) begin
					rx_st_q <= RX_IDLE;
				end
			end
		end
		default: begin
			rx_st_q <= RX_IDLE;
		end
		endcase
	end
end

// Software fields; hardware sets win over a clearing write
always @(posedge ref_clk) begin
	if (rst) begin
		sm0_q <= 1'b0;
		sm1_q <= 1'b0;
		sm2_q <= 1'b0;
		ren_q <= 1'b0;
		tb8_q <= 1'b0;
		rb8_q <= 1'b0;
		ti_q <= 1'b0;
		ri_q <= 1'b0;
		fe_q <= 1'b0;
		rate_sel_q <= 1'b0;
		view_sel_q <= 1'b0;
		rbuf_q <= 8'h00;
	end else begin
		if (wr_pwr) begin
			rate_sel_q <= reg_wdata[`ESP_BIT_RATE];
			view_sel_q <= reg_wdata[`ESP_BIT_VIEW];
		end
		if (wr_ctrl) begin
			if (view_sel_q) begin
				fe_q <= reg_wdata[`ESP_BIT_SM0] | fe_set;
			end else begin
				sm0_q <= reg_wdata[`ESP_BIT_SM0];
			end
			sm1_q <= reg_wdata[`ESP_BIT_SM1];
			sm2_q <= reg_wdata[`ESP_BIT_SM2];
			ren_q <= reg_wdata[`ESP_BIT_REN];
			tb8_q <= reg_wdata[`ESP_BIT_TB8];
		end
		if (fe_set) begin
			fe_q <= 1'b1;
		end
		if (wr_ctrl && !(m0_done && m0_rx_q) && !rx_load) begin
			rb8_q <= reg_wdata[`ESP_BIT_RB8];
		end else if (rx_load) begin
			rb8_q <= rx_ninth;
		end
		if (tx_done || (m0_done && !m0_rx_q)) begin
			ti_q <= 1'b1;
		end else if (wr_ctrl) begin
			ti_q <= reg_wdata[`ESP_BIT_TI];
		end
		if (rx_load || (m0_done && m0_rx_q)) begin
			ri_q <= 1'b1;
		end else if (wr_ctrl) begin
			ri_q <= reg_wdata[`ESP_BIT_RI];
		end
		// Overwrites an unread byte, as the port has one holding stage
		if (rx_load) begin
			rbuf_q <= rx_byte;
		end else if (m0_done && m0_rx_q) begin
			rbuf_q <= {rxd_v_q, m0_sh_q[7:1]};
		end
	end
end

// Read port, data valid the cycle after the strobe
always @(posedge ref_clk) begin
	if (rst) begin
		reg_rdata <= 8'h00;
	end else if (reg_rd) begin
		case (reg_addr)
		`ESP_ADDR_CTRL: begin
			reg_rdata <= {view_sel_q ? fe_q : sm0_q, sm1_q, sm2_q, ren_q,
				tb8_q, rb8_q, ti_q, ri_q};
		end
		`ESP_ADDR_BUF: begin
			reg_rdata <= rbuf_q;
		end
		`ESP_ADDR_PWR: begin
			reg_rdata <= {rate_sel_q, view_sel_q, 6'h00};
		end
		default: begin
			reg_rdata <= 8'h00;
		end
		endcase
	end else begin
		reg_rdata <= 8'h00;
	end
end

// Pin drivers; mode 0 turns the receive pin around
always @(posedge ref_clk) begin
	if (rst) begin
		txd_out <= 1'b1;
		rxd_out <= 1'b1;
		rxd_oe <= 1'b0;
	end else if (is_m0) begin
		txd_out <= !m0_busy_q || (m0_ph_q >= `ESP_M0_HALF);
		rxd_out <= m0_sh_q[0];
		rxd_oe <= m0_busy_q && !m0_rx_q;
	end else begin
		txd_out <= tx_busy_q ? tx_sh_q[0] : 1'b1;
		rxd_out <= 1'b1;
		rxd_oe <= 1'b0;
	end
end

endmodule // esp_top
